// >>> design/uos_pkg.sv
// Shared constants and types for the OTG status and frame number block.
package uos_pkg;

    // ==========================================================
    // Timing
    localparam int UOS_CLK_MHZ = 100;
    localparam int UOS_STABLE_US = 1000;
    localparam int UOS_CNT_W = 17;
    localparam logic [UOS_CNT_W-1:0] UOS_STABLE_CYC = UOS_CNT_W'(UOS_STABLE_US * UOS_CLK_MHZ);

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] UOS_OFS_OTG_STATUS = 8'h00;
    localparam logic [7:0] UOS_OFS_FRAME_LOW = 8'h04;
    localparam logic [7:0] UOS_OFS_FRAME_HIGH = 8'h08;
    localparam logic [7:0] UOS_OFS_INT_STATUS = 8'h0c;
    localparam logic [7:0] UOS_OFS_INT_ENABLE = 8'h10;
    localparam logic [7:0] UOS_OFS_INT_CLEAR = 8'h14;

    // ==========================================================
    // Field positions in otg_status
    localparam int UOS_BIT_CABLE = 7;
    localparam int UOS_BIT_LINE_STABLE = 5;
    localparam int UOS_BIT_SESSION = 3;
    localparam int UOS_BIT_B_END = 2;
    localparam int UOS_BIT_A_VALID = 0;

    // Frame number layout.
    localparam int UOS_FRAME_W = 11;
    localparam int UOS_FRAME_LOW_W = 8;
    localparam int UOS_FRAME_HIGH_W = 3;

    // Event bits of the interrupt registers.
    localparam int UOS_EV_N = 4;
    localparam int UOS_EV_SOF = 0;
    localparam int UOS_EV_STABLE = 1;
    localparam int UOS_EV_CABLE = 2;
    localparam int UOS_EV_POWER = 3;

    // Synchronised pin order.
    localparam int UOS_PIN_N = 4;
    localparam int UOS_PIN_CABLE = 3;
    localparam int UOS_PIN_SESSION = 2;
    localparam int UOS_PIN_B_END = 1;
    localparam int UOS_PIN_A_VALID = 0;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } uos_bus_req_t;

    typedef struct packed {
        logic valid;
        logic [UOS_FRAME_W-1:0] frame;
    } uos_sof_t;

    typedef struct packed {
        logic [UOS_PIN_N-1:0] sync1;
        logic [UOS_PIN_N-1:0] sync2;
        logic cable_type_flag;
        logic session_valid_flag;
        logic b_session_end_flag;
        logic a_bus_power_valid_flag;
        logic [1:0] line_prev;
        logic [UOS_CNT_W-1:0] stable_cnt;
        logic line_stable_flag;
        logic [UOS_FRAME_W-1:0] frame;
        logic [UOS_EV_N-1:0] int_status;
        logic [UOS_EV_N-1:0] int_enable;
        logic [31:0] rdata;
        logic irq;
    } uos_state_t;

    localparam uos_state_t UOS_STATE_RST = '0;

endpackage

// >>> design/uos_status.sv
// OTG status flags, line state stability timer and frame number capture.
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module uos_status
    import uos_pkg::*;
#(
    parameter logic [UOS_CNT_W-1:0] STABLE_CYCLES = UOS_STABLE_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire uos_bus_req_t bus_req,
    output logic [31:0] bus_rdata,
    output logic irq,
    input wire logic cable_id_pin,
    input wire logic a_session_valid_cmp,
    input wire logic b_session_end_cmp,
    input wire logic a_bus_valid_cmp,
    input wire logic se0_bit,
    input wire logic j_line_condition_bit,
    input wire uos_sof_t sof
);

    // ==========================================================
    // State
    uos_state_t q;
    uos_state_t d;

    logic [1:0] line_now;
    logic line_change;
    logic [UOS_EV_N-1:0] ev;
    logic [UOS_EV_N-1:0] clr;
    logic [31:0] otg_word;
    logic [31:0] low_word;
    logic [31:0] high_word;

    assign line_now = {j_line_condition_bit, se0_bit};
    assign line_change = (line_now != q.line_prev);

    // ==========================================================
    // Read views
    always_comb begin
        otg_word = '0;
        otg_word[UOS_BIT_CABLE] = q.cable_type_flag;
        otg_word[UOS_BIT_LINE_STABLE] = q.line_stable_flag;
        otg_word[UOS_BIT_SESSION] = q.session_valid_flag;
        otg_word[UOS_BIT_B_END] = q.b_session_end_flag;
        otg_word[UOS_BIT_A_VALID] = q.a_bus_power_valid_flag;
    end

    assign low_word = {24'h000000, q.frame[UOS_FRAME_LOW_W-1:0]};
    assign high_word = {29'h00000000, q.frame[UOS_FRAME_W-1:UOS_FRAME_LOW_W]};

    // ==========================================================
    // Next state
    always_comb begin
        d = q;

        // Pins come from outside the clock domain; only the second stage is read.
        d.sync1 = {cable_id_pin, a_session_valid_cmp, b_session_end_cmp, a_bus_valid_cmp};
        d.sync2 = q.sync1;

        d.cable_type_flag = q.sync2[UOS_PIN_CABLE];
        d.session_valid_flag = q.sync2[UOS_PIN_SESSION];
        d.b_session_end_flag = q.sync2[UOS_PIN_B_END];
        d.a_bus_power_valid_flag = q.sync2[UOS_PIN_A_VALID];

        // The line bits are already in this clock domain, so no synchroniser.
        d.line_prev = line_now;
        if (line_change) begin
            d.stable_cnt = '0;
        end else if (q.stable_cnt != STABLE_CYCLES) begin
            d.stable_cnt = q.stable_cnt + 1'b1;
        end
        d.line_stable_flag = !line_change && (d.stable_cnt == STABLE_CYCLES);

        if (sof.valid) begin
            d.frame = sof.frame;
        end

        // Events; a set in the same cycle as a clear wins.
        ev = '0;
        ev[UOS_EV_SOF] = sof.valid;
        ev[UOS_EV_STABLE] = d.line_stable_flag && !q.line_stable_flag;
        ev[UOS_EV_CABLE] = d.cable_type_flag != q.cable_type_flag;
        ev[UOS_EV_POWER] = (d.session_valid_flag != q.session_valid_flag)
            || (d.b_session_end_flag != q.b_session_end_flag)
            || (d.a_bus_power_valid_flag != q.a_bus_power_valid_flag);
        clr = '0;
        if (bus_req.wr && bus_req.addr == UOS_OFS_INT_CLEAR) begin
            clr = bus_req.wdata[UOS_EV_N-1:0];
        end
        if (bus_req.wr && bus_req.addr == UOS_OFS_INT_ENABLE) begin
            d.int_enable = bus_req.wdata[UOS_EV_N-1:0];
        end
        d.int_status = (q.int_status & ~clr) | ev;
        d.irq = |(d.int_status & d.int_enable);

        d.rdata = '0;
        if (bus_req.rd) begin
            case (bus_req.addr)
                UOS_OFS_OTG_STATUS: begin
                    d.rdata = otg_word;
                end
                UOS_OFS_FRAME_LOW: begin
                    d.rdata = low_word;
                end
                UOS_OFS_FRAME_HIGH: begin
                    d.rdata = high_word;
                end
                UOS_OFS_INT_STATUS: begin
                    d.rdata = {28'h0000000, q.int_status};
                end
                UOS_OFS_INT_ENABLE: begin
                    d.rdata = {28'h0000000, q.int_enable};
                end
                default: begin
                    d.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            q <= UOS_STATE_RST;
        end else begin
            q <= d;
        end
    end

    assign bus_rdata = q.rdata;
    assign irq = q.irq;

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence s_read_otg;
        bus_req.rd && bus_req.addr == UOS_OFS_OTG_STATUS;
    endsequence

    sequence s_line_moves;
        line_change;
    endsequence

    sequence s_token;
        sof.valid;
    endsequence

    sequence s_read_low;
        bus_req.rd && bus_req.addr == UOS_OFS_FRAME_LOW;
    endsequence

    sequence s_read_high;
        bus_req.rd && bus_req.addr == UOS_OFS_FRAME_HIGH;
    endsequence

    sequence s_clear_sof;
        bus_req.wr && bus_req.addr == UOS_OFS_INT_CLEAR && bus_req.wdata[UOS_EV_SOF];
    endsequence

    sequence s_line_quiet_full;
        !line_change && q.stable_cnt == STABLE_CYCLES;
    endsequence

    AST_CABLE_PATH: assert property (##3 q.cable_type_flag == $past(cable_id_pin, 3))
        else $error("Cable flag does not follow the cable pin.");

    AST_CABLE_READ: assert property (s_read_otg |=> bus_rdata[UOS_BIT_CABLE] == $past(q.cable_type_flag))
        else $error("Cable flag read back wrong.");

    AST_STABLE_CLEAR: assert property (s_line_moves |=> !q.line_stable_flag)
        else $error("Line stable flag set after a line change.");

    AST_STABLE_COUNT: assert property (q.line_stable_flag |-> q.stable_cnt == STABLE_CYCLES)
        else $error("Line stable flag set before the window expired.");

    AST_COUNT_RESTART: assert property (s_line_moves |=> q.stable_cnt == '0)
        else $error("Stability counter did not restart.");

    AST_COUNT_STEP: assert property (!line_change && q.stable_cnt != STABLE_CYCLES
        |=> q.stable_cnt == $past(q.stable_cnt) + 1'b1)
        else $error("Stability counter did not advance.");

    AST_SESSION_PATH: assert property (##3 q.session_valid_flag == $past(a_session_valid_cmp, 3))
        else $error("Session valid flag does not follow comparator.");

    AST_B_END_PATH: assert property (##3 q.b_session_end_flag == $past(b_session_end_cmp, 3))
        else $error("Session end flag does not follow comparator.");

    AST_A_VALID_PATH: assert property (##3 q.a_bus_power_valid_flag == $past(a_bus_valid_cmp, 3))
        else $error("Bus valid flag does not follow comparator.");

    AST_RESERVED_ZERO: assert property (s_read_otg |=> bus_rdata[31:8] == '0
        && !bus_rdata[6] && !bus_rdata[4] && !bus_rdata[1])
        else $error("Reserved status bits read nonzero.");

    AST_LOW_CAPTURE: assert property (s_token ##1 (bus_req.rd && bus_req.addr == UOS_OFS_FRAME_LOW)
        |=> bus_rdata[7:0] == $past(sof.frame[7:0], 2))
        else $error("Low frame bits not captured from token.");

    AST_HIGH_CAPTURE: assert property (s_token |=> q.frame[UOS_FRAME_W-1:UOS_FRAME_LOW_W]
        == $past(sof.frame[UOS_FRAME_W-1:UOS_FRAME_LOW_W]))
        else $error("High frame bits not captured from token.");

    AST_FRAME_HOLD: assert property (!sof.valid |=> $stable(q.frame))
        else $error("Frame number changed without a token.");

    AST_HIGH_ZERO: assert property (bus_req.rd && bus_req.addr == UOS_OFS_FRAME_HIGH
        |=> bus_rdata[31:3] == '0)
        else $error("High frame register upper bits nonzero.");

    AST_LOW_ZERO: assert property (bus_req.rd && bus_req.addr == UOS_OFS_FRAME_LOW
        |=> bus_rdata[31:8] == '0)
        else $error("Low frame register upper bits nonzero.");

    AST_WRITE_IGNORED: assert property (bus_req.wr && bus_req.addr == UOS_OFS_FRAME_LOW && !sof.valid
        |=> $stable(q.frame))
        else $error("Frame number changed on a software write.");

    AST_IRQ_LEVEL: assert property (##1 irq == |($past(d.int_status) & $past(d.int_enable)))
        else $error("Interrupt output disagrees with enabled status.");

    // ==========================================================
    // Read path checks
    AST_SESSION_READ: assert property (s_read_otg |=> bus_rdata[UOS_BIT_SESSION] == $past(q.session_valid_flag))
        else $error("Session valid flag read back wrong.");

    AST_B_END_READ: assert property (s_read_otg |=> bus_rdata[UOS_BIT_B_END] == $past(q.b_session_end_flag))
        else $error("Session end flag read back wrong.");

    AST_A_VALID_READ: assert property (s_read_otg |=> bus_rdata[UOS_BIT_A_VALID] == $past(q.a_bus_power_valid_flag))
        else $error("Bus valid flag read back wrong.");

    AST_STABLE_READ: assert property (s_read_otg |=> bus_rdata[UOS_BIT_LINE_STABLE] == $past(q.line_stable_flag))
        else $error("Line stable flag read back wrong.");

    AST_LOW_READ: assert property (s_read_low |=> bus_rdata[7:0] == $past(q.frame[UOS_FRAME_LOW_W-1:0]))
        else $error("Low frame field read back wrong.");

    AST_HIGH_READ: assert property (s_read_high
        |=> bus_rdata[2:0] == $past(q.frame[UOS_FRAME_W-1:UOS_FRAME_LOW_W]))
        else $error("High frame field read back wrong.");

    AST_RDATA_IDLE: assert property (!bus_req.rd |=> bus_rdata == '0)
        else $error("Read data not zero outside a read.");

    // ==========================================================
    // Timer checks
    AST_STABLE_SET: assert property (s_line_quiet_full |=> q.line_stable_flag)
        else $error("Line stable flag missing after full window.");

    AST_COUNT_SAT: assert property (s_line_quiet_full |=> q.stable_cnt == STABLE_CYCLES)
        else $error("Stability counter ran past the window.");

    AST_COUNT_BOUND: assert property (q.stable_cnt <= STABLE_CYCLES)
        else $error("Stability counter out of range.");

    // ==========================================================
    // Capture and write checks
    AST_LOW_LOAD: assert property (s_token |=> q.frame[UOS_FRAME_LOW_W-1:0] == $past(sof.frame[7:0]))
        else $error("Low frame bits not loaded from token.");

    AST_WRITE_HIGH_IGNORED: assert property (bus_req.wr && bus_req.addr == UOS_OFS_FRAME_HIGH && !sof.valid
        |=> $stable(q.frame))
        else $error("Frame number changed on a write to the high register.");

    AST_STATUS_WRITE_IGNORED: assert property (bus_req.wr && bus_req.addr == UOS_OFS_OTG_STATUS
        |=> q.cable_type_flag == $past(q.sync2[UOS_PIN_CABLE]))
        else $error("Cable flag moved by a software write.");

    // ==========================================================
    // Event checks
    AST_SOF_EVENT: assert property (s_token |=> q.int_status[UOS_EV_SOF])
        else $error("Token event not recorded.");

    AST_SOF_STICKY: assert property (q.int_status[UOS_EV_SOF] && !bus_req.wr |=> q.int_status[UOS_EV_SOF])
        else $error("Token event lost without a clear.");

    AST_SOF_CLEAR: assert property (s_clear_sof and !sof.valid |=> !q.int_status[UOS_EV_SOF])
        else $error("Token event not cleared.");

    AST_SOF_SET_WINS: assert property (s_clear_sof and sof.valid |=> q.int_status[UOS_EV_SOF])
        else $error("Clear beat a token event in the same cycle.");

    AST_STABLE_EVENT: assert property ($rose(q.line_stable_flag) |-> q.int_status[UOS_EV_STABLE])
        else $error("Line stable event not recorded.");

    AST_CABLE_EVENT: assert property ($changed(q.cable_type_flag) |-> q.int_status[UOS_EV_CABLE])
        else $error("Cable change event not recorded.");

    AST_POWER_EVENT: assert property ($changed(q.session_valid_flag) || $changed(q.b_session_end_flag)
        || $changed(q.a_bus_power_valid_flag) |-> q.int_status[UOS_EV_POWER])
        else $error("Power change event not recorded.");

    AST_IRQ_MASKED: assert property (q.int_enable == '0 |-> !irq)
        else $error("Interrupt raised with all events masked.");

endmodule // uos_status

`default_nettype wire

// >>> verif/uos_far_end.sv
// Model of the cable and remote USB party: bus power comparators, ID pin and SOF tokens.
`timescale 1ns/1ps
`default_nettype none
module uos_far_end
    import uos_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic sof_en,
    input wire logic [UOS_PIN_N-1:0] pins_cfg,
    output logic cable_id_pin,
    output logic a_session_valid_cmp,
    output logic b_session_end_cmp,
    output logic a_bus_valid_cmp,
    output uos_sof_t sof
);
    // ==========================================================
    // Pins and tokens
    // Tokens start near the top so the 11-bit wrap is crossed early.
    logic [3:0] gap_q;
    logic [UOS_FRAME_W-1:0] fn_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            gap_q <= '0;
            fn_q <= 11'h7fe;
            sof <= '0;
            {cable_id_pin, a_session_valid_cmp, b_session_end_cmp, a_bus_valid_cmp} <= '0;
        end else begin
            {cable_id_pin, a_session_valid_cmp, b_session_end_cmp, a_bus_valid_cmp} <= pins_cfg;
            gap_q <= gap_q + 4'h1;
            sof.valid <= sof_en && (gap_q == 4'hf);
            sof.frame <= fn_q;
            if (sof_en && (gap_q == 4'hf)) begin
                fn_q <= fn_q + 11'h001;
            end
        end
    end
endmodule // uos_far_end
`default_nettype wire

// >>> verif/usb_otg_status_frame_number_bench.sv
// Self-checking testbench for the OTG status and frame number block.
`timescale 1ns/1ps
`default_nettype none
module usb_otg_status_frame_number_bench;
    import uos_pkg::*;
    localparam logic [UOS_CNT_W-1:0] N_STB = 17'd20;
    logic mclk, rst, irq, se0, jl, sof_en, cab, sesv, bend, abv;
    logic [3:0] pins_cfg;
    logic [31:0] bus_rdata, d;
    uos_bus_req_t bus_req;
    uos_sof_t sof;
    int miscompares = 0;
    int n_tests = 0;
    uos_status #(.STABLE_CYCLES(N_STB)) u_uos_status (.mclk(mclk), .rst(rst), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .irq(irq), .cable_id_pin(cab), .a_session_valid_cmp(sesv),
        .b_session_end_cmp(bend), .a_bus_valid_cmp(abv), .se0_bit(se0), .j_line_condition_bit(jl),
        .sof(sof));
    uos_far_end u_uos_far_end (.mclk(mclk), .rst(rst), .sof_en(sof_en), .pins_cfg(pins_cfg),
        .cable_id_pin(cab), .a_session_valid_cmp(sesv), .b_session_end_cmp(bend),
        .a_bus_valid_cmp(abv), .sof(sof));
    // ==========================================================
    // Bus tasks and comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus_req.rd <= 1'b0;
        #1 v = bus_rdata;
    endtask
    task automatic conclude();
        $display("comparisons %0d, miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_pins();
        logic [3:0] pat [6] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'hf, 4'h0};
        foreach (pat[i]) begin
            @(posedge mclk);
            pins_cfg <= pat[i];
            wr(UOS_OFS_OTG_STATUS, 32'hffffffff);
            repeat (6) @(posedge mclk);
            rd(UOS_OFS_OTG_STATUS, d);
            chk(d & 32'hffffffdf, {24'h0, pat[i][3], 3'h0, pat[i][2], pat[i][1], 1'b0, pat[i][0]});
        end
    endtask
    task automatic t_line();
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk);
            if (k == 0) jl <= ~jl;
            else se0 <= ~se0;
            rd(UOS_OFS_OTG_STATUS, d);
            chk(d & 32'h20, 32'h0); // restart on change
            repeat (14) @(posedge mclk);
            rd(UOS_OFS_OTG_STATUS, d);
            chk(d & 32'h20, 32'h0); // not yet stable
            repeat (8) @(posedge mclk);
            rd(UOS_OFS_OTG_STATUS, d);
            chk(d & 32'h20, 32'h20); // stable after window
        end
    endtask
    task automatic t_sof();
        logic [10:0] f;
        int w;
        sof_en <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            w = 0;
            do begin
                @(posedge mclk);
                w++;
            end while (sof.valid !== 1'b1 && w < 100);
            f = sof.frame;
            rd(UOS_OFS_FRAME_LOW, d);
            chk(d, {24'h0, f[7:0]}); // low field
            rd(UOS_OFS_FRAME_HIGH, d);
            chk(d, {29'h0, f[10:8]}); // high field
        end
        wr(UOS_OFS_FRAME_LOW, 32'hffffffff);
        rd(UOS_OFS_FRAME_LOW, d);
        chk(d, {24'h0, f[7:0]}); // write ignored
    endtask
    task automatic t_irq();
        wr(UOS_OFS_INT_ENABLE, 32'h1);
        repeat (20) @(posedge mclk);
        chk({31'h0, irq}, 32'h1); // token interrupt
        sof_en <= 1'b0;
        wr(UOS_OFS_INT_ENABLE, 32'h0);
        repeat (2) @(posedge mclk);
        chk({31'h0, irq}, 32'h0); // masked
        rd(UOS_OFS_INT_STATUS, d);
        chk(d & 32'h1, 32'h1); // sticky event
        wr(UOS_OFS_INT_CLEAR, 32'hf);
        rd(UOS_OFS_INT_STATUS, d);
        chk(d, 32'h0); // cleared
        wr(UOS_OFS_INT_ENABLE, 32'hf);
        repeat (2) @(posedge mclk);
        chk({31'h0, irq}, 32'h0); // no pending event
        rd(8'h18, d);
        chk(d, 32'h0); // unmapped reads zero
    endtask
    // ==========================================================
    // Clock, reset, sequence and watchdog
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        rst = 1'b1;
        bus_req = '0;
        se0 = 1'b0;
        jl = 1'b0;
        sof_en = 1'b0;
        pins_cfg = 4'h0;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        rd(UOS_OFS_OTG_STATUS, d);
        chk(d, 32'h0); // reset value
        rd(UOS_OFS_FRAME_HIGH, d);
        chk(d, 32'h0); // reset value
        t_pins();
        t_line();
        t_sof();
        t_irq();
        conclude();
    end
    initial begin
        #300us;
        miscompares++;
        conclude();
    end
endmodule // usb_otg_status_frame_number_bench
`default_nettype wire
